// ===== design/cio_pkg.sv
// Notes on behaviour
// - all cpu i/o cycles leave in program order
// - non-posted i/o blocks memory and barrier retirement
// - full stores to enabled blocks post, partial stores and loads never
// - queued posted stores stall only later i/o, and only while the queue is full
// - posted store faults may report after retirement
// - load or non-posted store plus barrier drains queue
// - posting enable is diagnose register 13
// - split/lock may repeat, last, overlap traffic
// - every split cycle is handled as locked
// - split/lock release requests inbound write flush
// - timeout sets address error, raises machine check
// - read parity mismatch flags, checks, returns data
// - forced parity bits act one cycle only
// - forced parity errors behave like real ones
// - debug mode dumps 36 state bits idle
// - debug keeps request on, controls inactive
// - debug starts 1.5 bus states after events
// - debug stops before mastering or after release
// - no debug drive while a cycle runs
// - addresses f000_0000 upward are i/o space
package cio_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_STATUS = 10'h000;
  localparam logic [9:0] IDX_CONTROL = 10'h001;
  localparam logic [9:0] IDX_POSTED = 10'h00D;
  localparam logic [9:0] IDX_DEBUG = 10'h01A;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ST_ADDR_ERR = 0;
  localparam int ST_DATA_PAR = 1;
  localparam int CTL_FORCE_APAR = 0;
  localparam int CTL_FORCE_DPAR = 1;
  localparam int DBG_EN_BIT = 0;
  localparam int BLK_LSB = 24;
  localparam int BLK_BITS = 4;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] CONTROL_RST = 2'h0;
  localparam logic [15:0] POSTED_RST = 16'h0000;
  localparam logic [31:0] IO_SPACE_BASE = 32'hF000_0000;
  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_DIV_DEF = 3;
  localparam int TIMEOUT_STATES_DEF = 64;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int SYNC_STAGES = 3;
  localparam int DBG_START_HALF_STATES = 3;
  localparam logic [3:0] TYPE_READ = 4'h0;
  localparam logic [3:0] TYPE_WRITE = 4'h1;
  typedef enum logic [3:0] {
    BS_IDLE = 4'b0001,
    BS_ARB = 4'b0010,
    BS_ADDR = 4'b0100,
    BS_DATA = 4'b1000
  } cio_bus_state_type;
endpackage

// ===== design/cio_bus_master.sv
`timescale 1ns/1ps
module cio_bus_master #(
  parameter int BUS_DIV = cio_pkg::BUS_DIV_DEF,
  parameter int TIMEOUT_STATES = cio_pkg::TIMEOUT_STATES_DEF,
  parameter int FIFO_DEPTH = cio_pkg::FIFO_DEPTH_DEF
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error, unmapped
  input wire logic cpu_req_valid, // cpu access request
  output logic cpu_req_ready, // cpu access taken
  input wire logic cpu_req_write, // store when high
  input wire logic cpu_req_partial, // partial byte store
  input wire logic [31:0] cpu_req_addr, // physical address
  input wire logic [31:0] cpu_req_wdata, // store data
  output logic mem_req_valid, // memory access released
  output logic cpu_rsp_valid, // blocking access retired
  output logic [31:0] cpu_rsp_rdata, // load data
  input wire logic cpu_barrier_valid, // barrier wants retire
  output logic cpu_barrier_ready, // barrier may retire
  output logic machine_check_fault, // bus error pulse
  output logic dma_flush_req, // flush inbound buffers
  output logic bus_locked, // cycle treated locked
  input wire logic [35:0] core_debug_state, // state to dump
  output logic bus_request_n, // bus request
  input wire logic bus_grant_n, // bus grant pin
  output logic bus_addr_valid_n, // address valid
  output logic bus_write_n, // write cycle marker
  input wire logic slave_ready_n, // slave ready pin
  input wire logic split_lock_signal_n, // split/lock pin
  output logic [31:0] bus_data_lines_o, // data out
  output logic bus_data_lines_oe, // data enable
  input wire logic [31:0] bus_data_lines_i, // data in
  output logic [3:0] bus_type_o, // type lines out
  output logic bus_type_oe, // type lines enable
  output logic bus_parity_o, // parity out
  output logic bus_parity_oe, // parity enable
  input wire logic bus_parity_i // parity in
);
  import cio_pkg::*;

  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int DBG_DELAY = (BUS_DIV * DBG_START_HALF_STATES + 1) / 2;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl_q;
  logic [SYNC_STAGES-1:0] pin_sync_q [3];
  assign pin_raw = {~split_lock_signal_n, ~slave_ready_n, ~bus_grant_n};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_sync_q[g] <= '0;
        pin_lvl_q[g] <= 1'b0;
      end else begin
        pin_sync_q[g] <= {pin_sync_q[g][SYNC_STAGES-2:0], pin_raw[g]};
        if (pin_sync_q[g][1] == pin_sync_q[g][2]) begin
          pin_lvl_q[g] <= pin_sync_q[g][2];
        end
      end
    end
  end
  logic grant_s, ready_s, split_s;
  assign grant_s = pin_lvl_q[0];
  assign ready_s = pin_lvl_q[1];
  assign split_s = pin_lvl_q[2];

  // data path delayed to line up with the agreed control levels
  logic [32:0] rx_pipe_q [SYNC_STAGES+1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i <= SYNC_STAGES; i++) rx_pipe_q[i] <= '0;
    end else begin
      rx_pipe_q[0] <= {bus_parity_i, bus_data_lines_i};
      for (int i = 1; i <= SYNC_STAGES; i++) begin
        rx_pipe_q[i] <= rx_pipe_q[i-1];
      end
    end
  end
  logic [31:0] rx_data;
  logic rx_par;
  assign rx_data = rx_pipe_q[SYNC_STAGES][31:0];
  assign rx_par = rx_pipe_q[SYNC_STAGES][32];

  // ---------------------------------------------------------------
  // bus state divider
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic bus_en;
  assign bus_en = (div_q == 8'(BUS_DIV - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 8'h00;
    else if (bus_en) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // ---------------------------------------------------------------
  // registers over apb
  // ---------------------------------------------------------------
  logic [1:0] status_q;
  logic [1:0] control_q;
  logic [15:0] posted_store_enable_reg_q;
  logic debug_en_q;
  logic [9:0] pidx;
  logic apb_wr, apb_setup, mapped;
  logic [1:0] st_set;
  logic ctl_take;
  assign pidx = paddr[11:2];
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (pidx == IDX_STATUS) || (pidx == IDX_CONTROL) ||
                  (pidx == IDX_POSTED) || (pidx == IDX_DEBUG);
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      pslverr <= !mapped;
      unique case (pidx)
        IDX_STATUS: prdata <= {30'h0, status_q};
        IDX_CONTROL: prdata <= {30'h0, control_q};
        IDX_POSTED: prdata <= {16'h0000, posted_store_enable_reg_q};
        IDX_DEBUG: prdata <= {31'h0, debug_en_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // write one to clear; a same-cycle error still sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= ((apb_wr && pidx == IDX_STATUS) ?
                   (status_q & ~pwdata[1:0]) : status_q) | st_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      posted_store_enable_reg_q <= POSTED_RST;
      debug_en_q <= 1'b0;
    end else if (apb_wr) begin
      if (pidx == IDX_POSTED) posted_store_enable_reg_q <= pwdata[15:0];
      if (pidx == IDX_DEBUG) debug_en_q <= pwdata[DBG_EN_BIT];
    end
  end

  // force bits are consumed by the cycle that starts next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) control_q <= CONTROL_RST;
    else if (apb_wr && pidx == IDX_CONTROL) control_q <= pwdata[1:0];
    else if (ctl_take) control_q <= 2'h0;
  end

  // ---------------------------------------------------------------
  // cpu side and in-order queue
  // ---------------------------------------------------------------
  logic [31:0] q_addr [FIFO_DEPTH];
  logic [31:0] q_data [FIFO_DEPTH];
  logic q_write [FIFO_DEPTH];
  logic q_blk [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] cnt_q;
  logic fifo_full, fifo_empty, push, pop;
  logic is_io, is_posted, blocking_q;
  logic done, tout, par_err;

  assign fifo_full = (cnt_q == (PW+1)'(FIFO_DEPTH));
  assign fifo_empty = (cnt_q == '0);
  assign is_io = (cpu_req_addr >= IO_SPACE_BASE);
  // stores post in enabled blocks; partial byte stores and loads never
  assign is_posted = cpu_req_write && !cpu_req_partial &&
    posted_store_enable_reg_q[cpu_req_addr[BLK_LSB +: BLK_BITS]];
  // a blocking access holds off every later cpu access
  assign cpu_req_ready = !blocking_q && (!is_io || !fifo_full);
  assign push = cpu_req_valid && cpu_req_ready && is_io;
  assign mem_req_valid = cpu_req_valid && cpu_req_ready && !is_io;
  // posted stores do not hold a barrier back
  assign cpu_barrier_ready = cpu_barrier_valid && !blocking_q;
  assign pop = done;

  always_ff @(posedge pclk) begin
    if (push) begin
      q_addr[wr_ptr_q] <= cpu_req_addr;
      q_data[wr_ptr_q] <= cpu_req_wdata;
      q_write[wr_ptr_q] <= cpu_req_write;
      q_blk[wr_ptr_q] <= !is_posted;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == PW'(FIFO_DEPTH-1)) ? '0 :
                            wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= (rd_ptr_q == PW'(FIFO_DEPTH-1)) ? '0 :
                           rd_ptr_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  logic [31:0] h_addr, h_data;
  logic h_write, h_blk;
  assign h_addr = q_addr[rd_ptr_q];
  assign h_data = q_data[rd_ptr_q];
  assign h_write = q_write[rd_ptr_q];
  assign h_blk = q_blk[rd_ptr_q];

  // blocking entry is last in queue, so its end means the queue drained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blocking_q <= 1'b0;
      cpu_rsp_valid <= 1'b0;
      cpu_rsp_rdata <= 32'h0000_0000;
    end else begin
      cpu_rsp_valid <= done && h_blk;
      if (push && !is_posted) blocking_q <= 1'b1;
      else if (done && h_blk && cnt_q == (PW+1)'(1)) blocking_q <= 1'b0;
      if (done && h_blk && !h_write) cpu_rsp_rdata <= rx_data;
    end
  end

  blk_stall_a: assert property (blocking_q |-> !cpu_req_ready)
    else $error("access taken while blocking access pending");
  barrier_hold_a: assert property (
    (cpu_barrier_valid && blocking_q) |-> !cpu_barrier_ready)
    else $error("barrier retired with blocking i/o pending");
  posted_free_a: assert property (
    (cpu_req_valid && is_io && is_posted && !fifo_full && !blocking_q)
    |-> cpu_req_ready ##1 !blocking_q)
    else $error("posted store stalled or blocked later work");
  load_block_a: assert property (
    (push && !cpu_req_write) |=> blocking_q)
    else $error("i/o load did not wait for data");

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  cio_bus_state_type st_q, st_d;
  logic [15:0] tcnt_q;
  logic cyc_fap_q, cyc_fdp_q;
  logic req_act_q;

  always_comb begin
    st_d = st_q;
    done = 1'b0;
    tout = 1'b0;
    unique case (st_q)
      BS_IDLE: if (bus_en && !fifo_empty) st_d = BS_ARB;
      BS_ARB: if (bus_en && grant_s) st_d = BS_ADDR;
      BS_ADDR: if (bus_en) st_d = BS_DATA;
      BS_DATA: begin
        if (bus_en && ready_s) begin
          done = 1'b1;
          st_d = BS_IDLE;
        end else if (bus_en && !split_s &&
                     tcnt_q == 16'(TIMEOUT_STATES - 1)) begin
          tout = 1'b1;
          done = 1'b1;
          st_d = BS_IDLE;
        end
      end
    endcase
  end
  assign ctl_take = (st_q == BS_ARB) && (st_d == BS_ADDR);
  // forced bit flips the expected parity, so it fails like a real one
  assign par_err = done && !tout && !h_write &&
                   (rx_par != ((^rx_data) ^ cyc_fdp_q));
  assign st_set[ST_ADDR_ERR] = tout;
  assign st_set[ST_DATA_PAR] = par_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= BS_IDLE;
      tcnt_q <= 16'h0000;
      cyc_fap_q <= 1'b0;
      cyc_fdp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (ctl_take) begin
        cyc_fap_q <= control_q[CTL_FORCE_APAR];
        cyc_fdp_q <= control_q[CTL_FORCE_DPAR];
      end
      // a split stretches the cycle without limit
      if (st_q != BS_DATA || split_s) tcnt_q <= 16'h0000;
      else if (bus_en) tcnt_q <= tcnt_q + 16'h0001;
    end
  end

  // errors are reported when they occur, not tied to retirement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) machine_check_fault <= 1'b0;
    else machine_check_fault <= tout || par_err;
  end

  // every split is treated as a lock; release asks for a flush
  logic split_d_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      split_d_q <= 1'b0;
      dma_flush_req <= 1'b0;
      bus_locked <= 1'b0;
    end else begin
      split_d_q <= split_s;
      dma_flush_req <= split_d_q && !split_s;
      bus_locked <= split_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) req_act_q <= 1'b0;
    else if (bus_en) req_act_q <= !fifo_empty || st_q != BS_IDLE ||
                                  grant_s;
  end
  assign bus_request_n = !req_act_q;

  aerr_flag_a: assert property (tout |=> status_q[ST_ADDR_ERR] &&
                                machine_check_fault)
    else $error("timeout without address error and machine check");
  perr_mc_a: assert property (par_err |=> machine_check_fault &&
                              status_q[ST_DATA_PAR])
    else $error("read parity error not signalled");
  flush_rel_a: assert property ($fell(split_d_q) |-> dma_flush_req)
    else $error("split release did not request a flush");
  lock_a: assert property (split_s |=> bus_locked)
    else $error("split not treated as locked");

  // ---------------------------------------------------------------
  // debug dump on the idle bus
  // ---------------------------------------------------------------
  logic [7:0] dbg_cnt_q;
  logic debug_on_q, dbg_ok, dbg_start;
  assign dbg_ok = debug_en_q && grant_s && st_q == BS_IDLE &&
                  fifo_empty;
  assign dbg_start = (bus_en && grant_s && !req_act_q) || done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_cnt_q <= 8'h00;
      debug_on_q <= 1'b0;
    end else begin
      if (dbg_start) dbg_cnt_q <= 8'(DBG_DELAY);
      else if (dbg_cnt_q != 8'h00) dbg_cnt_q <= dbg_cnt_q - 8'h01;
      // queued work stops the dump ahead of the next cycle
      if (!dbg_ok || (bus_en && !req_act_q)) debug_on_q <= 1'b0;
      // once the start delay has run out, an idle granted bus dumps,
      // also when the mode is switched on in the middle of idle time
      else if (dbg_cnt_q == 8'h00 && !dbg_start && req_act_q)
        debug_on_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_addr_valid_n <= 1'b1;
      bus_write_n <= 1'b1;
      bus_data_lines_o <= 32'h0000_0000;
      bus_data_lines_oe <= 1'b0;
      bus_type_o <= 4'h0;
      bus_type_oe <= 1'b0;
      bus_parity_o <= 1'b0;
      bus_parity_oe <= 1'b0;
    end else begin
      bus_addr_valid_n <= !(st_q == BS_ADDR);
      bus_write_n <= !((st_q == BS_ADDR || st_q == BS_DATA) && h_write);
      bus_type_oe <= (st_q == BS_ADDR) || debug_on_q;
      if (st_q == BS_ADDR) begin
        bus_data_lines_o <= h_addr;
        bus_data_lines_oe <= 1'b1;
        bus_type_o <= h_write ? TYPE_WRITE : TYPE_READ;
        bus_parity_o <= (^h_addr) ^ cyc_fap_q;
        bus_parity_oe <= 1'b1;
      end else if (st_q == BS_DATA && h_write) begin
        bus_data_lines_o <= h_data;
        bus_data_lines_oe <= 1'b1;
        bus_parity_o <= (^h_data) ^ cyc_fdp_q;
        bus_parity_oe <= 1'b1;
      end else if (debug_on_q) begin
        bus_data_lines_o <= core_debug_state[31:0];
        bus_type_o <= core_debug_state[35:32];
        bus_data_lines_oe <= 1'b1;
        bus_parity_o <= ^core_debug_state;
        bus_parity_oe <= 1'b1;
      end else begin
        bus_data_lines_oe <= 1'b0;
        bus_parity_oe <= 1'b0;
      end
    end
  end

  dbg_ctrl_a: assert property (debug_on_q |=> bus_addr_valid_n &&
                               bus_write_n && !bus_request_n)
    else $error("control active while dumping debug data");
  dbg_nocyc_a: assert property ((st_q != BS_IDLE) |-> !debug_on_q)
    else $error("debug drive during a bus cycle");
  dbg_order_a: assert property ((st_q == BS_IDLE && st_d == BS_ARB)
                                |=> !debug_on_q)
    else $error("debug still on when mastering begins");
endmodule // cio_bus_master

// ===== tb/cio_slave_model.sv
`timescale 1ns/1ps
module cio_slave_model (
  input wire logic pclk, // core clock
  input wire logic presetn, // reset, low
  input wire logic bus_addr_valid_n, // address phase
  input wire logic bus_write_n, // write marker
  input wire logic [31:0] bus_data_lines_o, // lines from master
  input wire logic bus_parity_o, // parity from master
  input wire logic answer, // low lets the cycle time out
  input wire logic bad_par, // flip read parity
  input wire logic split, // split/lock before answering
  input wire logic [31:0] rd_word, // read return word
  output logic slave_ready_n, // ready pin
  output logic split_lock_signal_n, // split/lock pin
  output logic [31:0] bus_data_lines_i, // lines to master
  output logic bus_parity_i // parity to master
);
  logic busy_q;
  logic wr_q;
  logic wpar_bad_q;
  int cnt_q;
  int nlog_q;
  int go;
  logic [31:0] log_q [16];
  assign go = split ? 40 : 4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      wr_q <= 1'b0;
      wpar_bad_q <= 1'b0;
      cnt_q <= 0;
      nlog_q <= 0;
      slave_ready_n <= 1'b1;
      split_lock_signal_n <= 1'b1;
      bus_data_lines_i <= 32'h0000_0000;
      bus_parity_i <= 1'b0;
    end else begin
      // released lines change every cycle, never keep the last word
      bus_data_lines_i <= ~bus_data_lines_i;
      bus_parity_i <= ~bus_parity_i;
      slave_ready_n <= 1'b1;
      split_lock_signal_n <= 1'b1;
      if (!busy_q && !bus_addr_valid_n) begin
        busy_q <= 1'b1;
        cnt_q <= 0;
        wr_q <= !bus_write_n;
        log_q[nlog_q % 16] <= bus_data_lines_o;
        nlog_q <= nlog_q + 1;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 1;
        // split held long, and no broadcast reset is ever sent
        if (split && cnt_q >= 2 && cnt_q < 30) split_lock_signal_n <= 1'b0;
        if (answer && cnt_q >= go && cnt_q < go + 6) begin
          slave_ready_n <= 1'b0;
          bus_data_lines_i <= rd_word;
          bus_parity_i <= (^rd_word) ^ bad_par;
          // bad write parity is only noted; the word is kept anyway
          if (wr_q) wpar_bad_q <= (^bus_data_lines_o) != bus_parity_o;
        end
        if (cnt_q == go + 6) busy_q <= 1'b0;
      end
    end
  end
endmodule // cio_slave_model

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  import cio_pkg::*;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} cio_row_type;
  typedef struct {logic an; logic bd; logic [31:0] ct; logic [31:0] st;} cio_err_type;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cpu_req_valid = 1'b0, cpu_req_write = 1'b0;
  logic cpu_req_partial = 1'b0, cpu_barrier_valid = 1'b0, bus_grant_n = 1'b0;
  logic ans = 1'b1, bad = 1'b0, spl = 1'b0, mv, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, cpu_req_addr = 32'h0000_0000;
  logic [31:0] cpu_req_wdata = 32'h0000_0000, rdw = 32'h5A3C_0F81, r;
  logic [35:0] core_debug_state = 36'h9_1234_5678;
  logic pready, pslverr, cpu_req_ready, mem_req_valid, cpu_rsp_valid;
  logic cpu_barrier_ready, machine_check_fault, dma_flush_req, bus_locked;
  logic bus_request_n, bus_addr_valid_n, bus_write_n, slave_ready_n;
  logic split_lock_signal_n, bus_data_lines_oe, bus_type_oe, bus_parity_o;
  logic bus_parity_oe, bus_parity_i;
  logic [31:0] prdata, cpu_rsp_rdata, bus_data_lines_o, bus_data_lines_i;
  logic [3:0] bus_type_o;
  int errors = 0, comparisons = 0, mcf_n = 0, fl_n = 0, lk_n = 0, n0, m;
  cio_row_type rows [8] = '{'{0, 12'h000, 0, 0}, '{0, 12'h004, 0, 0},
    '{0, 12'h034, 0, 0}, '{1, 12'h034, 32'hFFFF_0003, 0},
    '{0, 12'h034, 32'h0000_0003, 0}, '{1, 12'h068, 32'h0000_0001, 0},
    '{0, 12'h068, 32'h0000_0001, 0}, '{0, 12'h010, 0, 1}};
  cio_err_type errs [4] = '{'{0, 0, 0, 32'h0000_0001},
    '{1, 1, 0, 32'h0000_0002}, '{1, 0, 32'h0000_0002, 32'h0000_0002},
    '{1, 0, 0, 0}};
  always #5 pclk = ~pclk;
  always @(negedge pclk) begin
    mcf_n += machine_check_fault;
    fl_n += dma_flush_req;
    lk_n += bus_locked;
  end
  cio_bus_master #(.BUS_DIV(3), .TIMEOUT_STATES(6), .FIFO_DEPTH(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .cpu_req_valid, .cpu_req_ready, .cpu_req_write,
    .cpu_req_partial, .cpu_req_addr, .cpu_req_wdata, .mem_req_valid,
    .cpu_rsp_valid, .cpu_rsp_rdata, .cpu_barrier_valid, .cpu_barrier_ready,
    .machine_check_fault, .dma_flush_req, .bus_locked, .core_debug_state,
    .bus_request_n, .bus_grant_n, .bus_addr_valid_n, .bus_write_n,
    .slave_ready_n, .split_lock_signal_n, .bus_data_lines_o,
    .bus_data_lines_oe, .bus_data_lines_i, .bus_type_o, .bus_type_oe,
    .bus_parity_o, .bus_parity_oe, .bus_parity_i);
  cio_slave_model slv (.pclk, .presetn, .bus_addr_valid_n, .bus_write_n,
    .bus_data_lines_o, .bus_parity_o, .answer(ans), .bad_par(bad),
    .split(spl), .rd_word(rdw), .slave_ready_n, .split_lock_signal_n,
    .bus_data_lines_i, .bus_parity_i);
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cpu(input logic w, input logic p, input logic [31:0] a);
    int n = 0;
    @(posedge pclk);
    cpu_req_valid <= 1'b1;
    cpu_req_write <= w;
    cpu_req_partial <= p;
    cpu_req_addr <= a;
    cpu_req_wdata <= ~a;
    do begin
      @(negedge pclk);
      n++;
    end while (cpu_req_ready !== 1'b1 && n < 400);
    if (cpu_req_ready !== 1'b1) errors++;
    mv = mem_req_valid;
    @(posedge pclk);
    cpu_req_valid <= 1'b0;
  endtask
  task automatic wait_rsp(input logic dchk);
    int n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (cpu_rsp_valid !== 1'b1 && n < 400);
    chk(cpu_rsp_valid, 1);
    if (dchk) chk(cpu_rsp_rdata, rdw);
  endtask
  function automatic logic [31:0] ad(input int i);
    return ((i % 2) ? 32'hF100_0100 : 32'hF000_0100) + 32'(4 * i);
  endfunction
  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      if (!rows[i].w) chk(r, rows[i].d);
    end
    apb(1'b1, 12'h068, 0);
    cpu(1'b1, 1'b0, 32'hEFFF_FFFC);
    chk(mv, 1);
    cpu(1'b0, 1'b0, 32'hF000_0000);
    chk(mv, 0);
    wait_rsp(1'b1);
    n0 = slv.nlog_q;
    @(posedge pclk);
    bus_grant_n <= 1'b1;
    cpu_barrier_valid <= 1'b1;
    for (int i = 0; i < 4; i++) cpu(1'b1, 1'b0, ad(i));
    @(posedge pclk);
    cpu_req_valid <= 1'b1;
    cpu_req_addr <= ad(4);
    @(negedge pclk);
    chk(cpu_req_ready, 0);
    chk(cpu_barrier_ready, 1);
    @(posedge pclk);
    bus_grant_n <= 1'b0;
    cpu(1'b1, 1'b0, ad(4));
    cpu(1'b1, 1'b1, 32'hF000_0180);
    @(negedge pclk);
    chk(cpu_barrier_ready, 0);
    wait_rsp(1'b0);
    cpu(1'b0, 1'b0, 32'hF000_0200);
    wait_rsp(1'b1);
    for (int i = 0; i < 5; i++) chk(slv.log_q[(n0 + i) % 16], ad(i));
    chk(slv.log_q[(n0 + 6) % 16], 32'hF000_0200);
    chk(slv.wpar_bad_q, 0);
    foreach (errs[i]) begin
      ans <= errs[i].an;
      bad <= errs[i].bd;
      apb(1'b1, 12'h004, errs[i].ct);
      m = mcf_n;
      cpu(1'b0, 1'b0, 32'hF000_0400);
      wait_rsp(errs[i].an);
      repeat (8) @(posedge pclk);
      chk(mcf_n - m, errs[i].st != 0);
      apb(1'b0, 12'h000, 0);
      chk(r, errs[i].st);
      apb(1'b1, 12'h000, errs[i].st);
      apb(1'b0, 12'h004, 0);
      chk(r, 0);
    end
    spl <= 1'b1;
    m = fl_n;
    n0 = lk_n;
    cpu(1'b0, 1'b0, 32'hF000_0300);
    wait_rsp(1'b1);
    spl <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(fl_n - m, 1);
    chk(lk_n > n0, 1);
    apb(1'b1, 12'h068, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    chk(bus_data_lines_oe, 1);
    chk({bus_type_o, bus_data_lines_o}, core_debug_state);
    chk({bus_request_n, bus_addr_valid_n, bus_write_n}, 3'b011);
    apb(1'b1, 12'h004, 32'h0000_0001);
    cpu(1'b0, 1'b0, 32'hF000_0500);
    m = 0;
    while (bus_addr_valid_n !== 1'b0 && m < 200) begin
      @(negedge pclk);
      m++;
    end
    chk(bus_data_lines_o, 32'hF000_0500);
    chk(bus_parity_o, ~^32'hF000_0500);
    wait_rsp(1'b1);
    apb(1'b1, 12'h068, 0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({bus_request_n, bus_addr_valid_n, bus_write_n, bus_data_lines_oe,
         machine_check_fault, cpu_rsp_valid}, 6'b111000);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h068, 0);
    chk(r, 0);
    give_verdict();
  end
  initial begin
    #900_000;
    errors++;
    give_verdict();
  end
endmodule // tb
